/* File: rlh_pkg.sv */
package rlh_pkg;

  localparam int          RLH_DATA_W       = 32;
  localparam int          RLH_ADDR_W       = 5;
  localparam int          RLH_DAC_W        = 10;
  localparam int          RLH_CNT_W        = 14;
  localparam int          RLH_LOS_CNT_W    = 6;
  localparam int          RLH_NUM_REFS     = 3;

  // Register numbers carried in the low bits of each serial word
  localparam logic [4:0]  RLH_ADDR_INPUT_MON = 5'h0e;
  localparam logic [4:0]  RLH_ADDR_DAC_HOLD  = 5'h0f;
  localparam logic [4:0]  RLH_ADDR_DAC_RB    = 5'h17;

  // input_monitor_config fields
  localparam int          RLH_LOS_SEL_LSB  = 30;
  localparam int          RLH_LOS_EN_BIT   = 28;
  localparam int          RLH_PIN_TYPE_LSB = 24;
  localparam int          RLH_BUF_SEL_LSB  = 20;
  localparam int          RLH_HI_TRIP_LSB  = 14;
  localparam int          RLH_LO_TRIP_LSB  = 6;
  localparam int          RLH_RAIL_EN_BIT  = 5;

  // dac_holdover_control fields
  localparam int          RLH_MAN_CODE_LSB = 22;
  localparam int          RLH_MAN_MODE_BIT = 20;
  localparam int          RLH_EXIT_CNT_LSB = 6;
  localparam int          RLH_FORCE_BIT    = 5;

  // dac_count_readback field
  localparam int          RLH_RB_CODE_LSB  = 14;

  localparam logic [31:0] RLH_INPUT_MON_RST = 32'h00000000;
  localparam logic [31:0] RLH_DAC_HOLD_RST  = 32'h00000040;

  // Input status pin io types
  localparam logic [2:0]  RLH_PIN_IN       = 3'h0;
  localparam logic [2:0]  RLH_PIN_IN_PU    = 3'h1;
  localparam logic [2:0]  RLH_PIN_IN_PD    = 3'h2;
  localparam logic [2:0]  RLH_PIN_PP       = 3'h3;
  localparam logic [2:0]  RLH_PIN_PP_INV   = 3'h4;
  localparam logic [2:0]  RLH_PIN_OS       = 3'h5;
  localparam logic [2:0]  RLH_PIN_OD       = 3'h6;

  localparam logic [9:0]  RLH_DAC_FULL     = 10'h3ff;
  localparam int          RLH_TRIP_STEPS   = 64;

  // Timing, picoseconds
  localparam int          RLH_CLK_PERIOD_PS = 25000;
  localparam int          RLH_LOS_T0_PS     = 1200000;
  localparam int          RLH_LOS_T1_PS     = 206000;
  localparam int          RLH_LOS_T2_PS     = 52900;
  localparam int          RLH_LOS_T3_PS     = 23700;

  // Least time: round up, never below one cycle
  function automatic int rlh_cycles_up(input int t_ps);
    int c;
    c = (t_ps + RLH_CLK_PERIOD_PS - 1) / RLH_CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [5:0]  RLH_LOS_CYC0 = 6'(rlh_cycles_up(RLH_LOS_T0_PS));
  localparam logic [5:0]  RLH_LOS_CYC1 = 6'(rlh_cycles_up(RLH_LOS_T1_PS));
  localparam logic [5:0]  RLH_LOS_CYC2 = 6'(rlh_cycles_up(RLH_LOS_T2_PS));
  localparam logic [5:0]  RLH_LOS_CYC3 = 6'(rlh_cycles_up(RLH_LOS_T3_PS));

  typedef enum logic {RLH_ST_TRACK, RLH_ST_HOLD} rlh_hold_state_t;

endpackage

/* File: rlh_core_if.sv */
`timescale 1ns/10ps
interface rlh_core_if;
  import rlh_pkg::*;
  logic                    wr_stb;
  logic [RLH_DATA_W-1:0]   wr_word;
  logic [RLH_DATA_W-1:0]   rb_word;
  logic                    los_enable;
  logic [1:0]              los_sel;
  logic [RLH_NUM_REFS-1:0] los_flags;

  modport ser  (output wr_stb, output wr_word, input rb_word);
  modport mon  (input los_enable, input los_sel, output los_flags);
  modport core (input wr_stb, input wr_word, output rb_word,
                output los_enable, output los_sel, input los_flags);
endinterface

/* File: rlh_serial_port.sv */
`timescale 1ns/10ps
module rlh_serial_port
  import rlh_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  input  wire logic ce_in,
  input  wire logic uwire_clk_in,
  input  wire logic uwire_data_in,
  input  wire logic uwire_le_in,
  output logic      readback_out,
  rlh_core_if.ser   bus
);

  typedef struct packed {
    logic [RLH_DATA_W-1:0] shift;
    logic [RLH_DATA_W-1:0] rb;
    logic                  clk_d;
    logic                  le_d;
    logic                  stb;
    logic [RLH_DATA_W-1:0] word;
  } rlh_ser_state_t;

  rlh_ser_state_t st;
  rlh_ser_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.clk_d = uwire_clk_in;
    next_st.le_d = uwire_le_in;
    next_st.stb = 1'b0;
    // Data is taken MSB first on the serial clock rising edge
    if (uwire_clk_in && !st.clk_d) begin
      next_st.shift = {st.shift[RLH_DATA_W-2:0], uwire_data_in};
      next_st.rb = {st.rb[RLH_DATA_W-2:0], 1'b0};
    end
    // Latch enable commits the word and reloads the readback shifter
    if (uwire_le_in && !st.le_d) begin
      next_st.stb = 1'b1;
      next_st.word = st.shift;
      next_st.rb = bus.rb_word;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= '0;
    end else if (ce_in) begin
      st <= next_st;
    end
  end

  assign bus.wr_stb = st.stb;
  assign bus.wr_word = st.word;
  assign readback_out = st.rb[RLH_DATA_W-1];

endmodule

/* File: rlh_los_monitor.sv */
`timescale 1ns/10ps
module rlh_los_monitor
  import rlh_pkg::*;
#(
  parameter int NUM_REFS = RLH_NUM_REFS
) (
  input  wire logic                clk_in,
  input  wire logic                arst_n_in,
  input  wire logic                ce_in,
  input  wire logic [NUM_REFS-1:0] ref_clk_in,
  rlh_core_if.mon                  mon
);

  typedef struct packed {
    logic [NUM_REFS-1:0][RLH_LOS_CNT_W-1:0] cnt;
    logic [NUM_REFS-1:0]                    prev;
    logic [NUM_REFS-1:0]                    los;
  } rlh_los_state_t;

  rlh_los_state_t st;
  rlh_los_state_t next_st;
  logic [RLH_LOS_CNT_W-1:0] limit;

  always_comb begin
    case (mon.los_sel)
      2'h0: limit = RLH_LOS_CYC0;
      2'h1: limit = RLH_LOS_CYC1;
      2'h2: limit = RLH_LOS_CYC2;
      default: limit = RLH_LOS_CYC3;
    endcase
  end

  always_comb begin
    next_st = st;
    next_st.prev = ref_clk_in;
    for (int i = 0; i < NUM_REFS; i++) begin
      if (!mon.los_enable) begin
        next_st.cnt[i] = '0;
        next_st.los[i] = 1'b0;
      end else if (ref_clk_in[i] != st.prev[i]) begin
        // Any edge is activity and restarts the wait
        next_st.cnt[i] = '0;
        next_st.los[i] = 1'b0;
      end else if (st.cnt[i] + 6'h01 >= limit) begin
        next_st.los[i] = 1'b1;
      end else begin
        next_st.cnt[i] = st.cnt[i] + 6'h01;
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= '0;
    end else if (ce_in) begin
      st <= next_st;
    end
  end

  assign mon.los_flags = st.los;

endmodule

/* File: rlh_holdover_ctrl.sv */
`timescale 1ns/10ps
// Operation
// - Selected timeout declares signal loss when enabled
// - Inactive reference input is flagged lost
// - Three-bit field sets status pin io type
// - Per-input bit chooses bipolar or CMOS buffer
// - Upper trip level enters holdover, sets flag
// - Lower trip level enters holdover, sets flag
// - Rail trip invalidates input, signals switch event
// - Manual code drives DAC in manual mode
// - Mode bit chooses automatic or manual DAC
// - Exit holdover after programmed locked cycle count
// - Force bit holds device in holdover
// - Forced holdover uses manual or tracked code
// - Forcing enters holdover without a switch event
// - DAC count readable at bits 23:14
// - Inhibit blocks holdover and switch on lock loss
// - Tracking follows tune voltage, always readable
module rlh_holdover_ctrl
  import rlh_pkg::*;
#(
  parameter int NUM_REFS = RLH_NUM_REFS,
  parameter int DAC_W    = RLH_DAC_W
) (
  input  wire logic                clk_in,
  input  wire logic                arst_n_in,
  input  wire logic                ce_in,
  input  wire logic                uwire_clk_in,
  input  wire logic                uwire_data_in,
  input  wire logic                uwire_le_in,
  input  wire logic [NUM_REFS-1:0] ref_clk_in,
  input  wire logic                first_loop_lock_flag_in,
  input  wire logic                pd_tick_in,
  input  wire logic [DAC_W-1:0]    tune_track_code_in,
  input  wire logic                track_enable_in,
  input  wire logic                lock_loss_switch_inhibit_in,
  output logic                     readback_out,
  output logic [NUM_REFS-1:0]      signal_loss_out,
  output logic [DAC_W-1:0]         tune_code_out,
  output logic                     holdover_out,
  output logic                     rail_high_out,
  output logic                     rail_low_out,
  output logic                     switch_event_out,
  output logic                     status1_o_out,
  output logic                     status1_oe_out,
  output logic                     status1_pullup_out,
  output logic                     status1_pulldown_out,
  output logic [NUM_REFS-1:0]      ref_input_buffer_select_out
);

  typedef struct packed {
    logic [RLH_DATA_W-1:0] input_monitor_config;
    logic [RLH_DATA_W-1:0] dac_holdover_control;
    rlh_hold_state_t       state;
    logic [DAC_W-1:0]      dac;
    logic                  lock_d;
    logic                  trip_d;
    logic                  force_d;
    logic [RLH_CNT_W-1:0]  lock_cnt;
    logic                  rail_hi;
    logic                  rail_lo;
    logic                  switch_evt;
    logic                  pin_o;
    logic                  pin_oe;
    logic                  pin_pu;
    logic                  pin_pd;
  } rlh_ctrl_state_t;

  rlh_ctrl_state_t st;
  rlh_ctrl_state_t next_st;

  rlh_core_if core_bus ();

  rlh_serial_port u_serial (
    .clk_in        (clk_in),
    .arst_n_in     (arst_n_in),
    .ce_in         (ce_in),
    .uwire_clk_in  (uwire_clk_in),
    .uwire_data_in (uwire_data_in),
    .uwire_le_in   (uwire_le_in),
    .readback_out  (readback_out),
    .bus           (core_bus.ser)
  );

  rlh_los_monitor #(
    .NUM_REFS (NUM_REFS)
  ) u_los (
    .clk_in     (clk_in),
    .arst_n_in  (arst_n_in),
    .ce_in      (ce_in),
    .ref_clk_in (ref_clk_in),
    .mon        (core_bus.mon)
  );

  // Trip distance in DAC codes for a 6-bit step code, (n+1)/64 of full scale
  function automatic logic [DAC_W-1:0] trip_span(input logic [5:0] code);
    logic [15:0] prod;
    prod = (16'(code) + 16'h0001) * 16'(RLH_DAC_FULL);
    return DAC_W'(prod / 16'(RLH_TRIP_STEPS));
  endfunction

  // Field views of the programmed registers
  logic [1:0]           los_sel;
  logic                 los_en;
  logic [2:0]           pin_type;
  logic [5:0]           hi_code;
  logic [5:0]           lo_code;
  logic                 rail_en;
  logic [DAC_W-1:0]     man_code;
  logic                 man_mode;
  logic [RLH_CNT_W-1:0] exit_cnt;
  logic                 force_hold;
  logic [DAC_W-1:0]     hi_level;
  logic [DAC_W-1:0]     lo_level;
  logic                 hit_hi;
  logic                 hit_lo;
  logic                 trip;
  logic                 lock_fall;
  logic                 pin_val;

  always_comb begin
    los_sel    = st.input_monitor_config[RLH_LOS_SEL_LSB +: 2];
    los_en     = st.input_monitor_config[RLH_LOS_EN_BIT];
    pin_type   = st.input_monitor_config[RLH_PIN_TYPE_LSB +: 3];
    hi_code    = st.input_monitor_config[RLH_HI_TRIP_LSB +: 6];
    lo_code    = st.input_monitor_config[RLH_LO_TRIP_LSB +: 6];
    rail_en    = st.input_monitor_config[RLH_RAIL_EN_BIT];
    man_code   = st.dac_holdover_control[RLH_MAN_CODE_LSB +: DAC_W];
    man_mode   = st.dac_holdover_control[RLH_MAN_MODE_BIT];
    exit_cnt   = st.dac_holdover_control[RLH_EXIT_CNT_LSB +: RLH_CNT_W];
    force_hold = st.dac_holdover_control[RLH_FORCE_BIT];
    hi_level   = RLH_DAC_FULL - trip_span(hi_code);
    lo_level   = trip_span(lo_code);
    hit_hi     = rail_en && (st.dac >= hi_level);
    hit_lo     = rail_en && (st.dac <= lo_level);
    trip       = hit_hi || hit_lo;
    // Lock loss counts only when not inhibited
    lock_fall  = st.lock_d && !first_loop_lock_flag_in
                 && !lock_loss_switch_inhibit_in;
    pin_val    = signal_loss_out[1];
  end

  assign core_bus.los_enable = los_en;
  assign core_bus.los_sel = los_sel;
  // Only the DAC count field is driven; the rest reads as zero
  assign core_bus.rb_word = RLH_DATA_W'({st.dac, RLH_RB_CODE_LSB'(0)});

  always_comb begin
    next_st = st;
    next_st.lock_d = first_loop_lock_flag_in;
    next_st.trip_d = trip;
    next_st.force_d = force_hold;
    next_st.switch_evt = 1'b0;
    next_st.rail_hi = hit_hi;
    next_st.rail_lo = hit_lo;

    // Readback register has no write path; a stray write is dropped
    if (core_bus.wr_stb) begin
      case (core_bus.wr_word[RLH_ADDR_W-1:0])
        RLH_ADDR_INPUT_MON: next_st.input_monitor_config = core_bus.wr_word;
        RLH_ADDR_DAC_HOLD:  next_st.dac_holdover_control = core_bus.wr_word;
        default: ;
      endcase
    end

    // DAC source
    if (man_mode) begin
      next_st.dac = man_code;
    end else if (st.state == RLH_ST_HOLD) begin
      if (!track_enable_in) begin
        next_st.dac = man_code;
      end
    end else if (track_enable_in) begin
      next_st.dac = tune_track_code_in;
    end

    // Switch event on a fresh rail trip or an uninhibited lock loss
    if ((trip && !st.trip_d) || lock_fall) begin
      next_st.switch_evt = 1'b1;
    end

    case (st.state)
      RLH_ST_TRACK: begin
        next_st.lock_cnt = '0;
        if (force_hold || trip || lock_fall) begin
          next_st.state = RLH_ST_HOLD;
        end
      end
      RLH_ST_HOLD: begin
        if (force_hold || trip || !first_loop_lock_flag_in) begin
          next_st.lock_cnt = '0;
        end else if (pd_tick_in) begin
          // Reserved zero count behaves as one
          if (st.lock_cnt + 14'h0001 >= exit_cnt) begin
            next_st.state = RLH_ST_TRACK;
            next_st.lock_cnt = '0;
          end else begin
            next_st.lock_cnt = st.lock_cnt + 14'h0001;
          end
        end
      end
      default: begin
        next_st.state = RLH_ST_TRACK;
      end
    endcase

    // Status pin driver, carries input 1 signal loss
    next_st.pin_o = 1'b0;
    next_st.pin_oe = 1'b0;
    next_st.pin_pu = 1'b0;
    next_st.pin_pd = 1'b0;
    case (pin_type)
      RLH_PIN_IN_PU: next_st.pin_pu = 1'b1;
      RLH_PIN_IN_PD: next_st.pin_pd = 1'b1;
      RLH_PIN_PP: begin
        next_st.pin_o = pin_val;
        next_st.pin_oe = 1'b1;
      end
      RLH_PIN_PP_INV: begin
        next_st.pin_o = !pin_val;
        next_st.pin_oe = 1'b1;
      end
      RLH_PIN_OS: begin
        next_st.pin_o = 1'b1;
        next_st.pin_oe = pin_val;
      end
      RLH_PIN_OD: begin
        next_st.pin_o = 1'b0;
        next_st.pin_oe = !pin_val;
      end
      default: ;
    endcase
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= '0;
      st.input_monitor_config <= RLH_INPUT_MON_RST;
      st.dac_holdover_control <= RLH_DAC_HOLD_RST;
      st.state <= RLH_ST_TRACK;
    end else if (ce_in) begin
      st <= next_st;
    end
  end

  assign signal_loss_out = core_bus.los_flags;
  assign tune_code_out = st.dac;
  assign holdover_out = (st.state == RLH_ST_HOLD);
  assign rail_high_out = st.rail_hi;
  assign rail_low_out = st.rail_lo;
  assign switch_event_out = st.switch_evt;
  assign status1_o_out = st.pin_o;
  assign status1_oe_out = st.pin_oe;
  assign status1_pullup_out = st.pin_pu;
  assign status1_pulldown_out = st.pin_pd;
  assign ref_input_buffer_select_out =
    st.input_monitor_config[RLH_BUF_SEL_LSB +: NUM_REFS];

endmodule

/* File: rlh_holdover_ctrl_monitor.sv */
`timescale 1ns/10ps
module rlh_holdover_ctrl_monitor
  import rlh_pkg::*;
#(
  parameter int NUM_REFS = RLH_NUM_REFS
) (
  input wire logic                clk_in,
  input wire logic                arst_n_in,
  input wire logic [NUM_REFS-1:0] ref_clk_in,
  input wire logic                first_loop_lock_flag_in,
  input wire logic                pd_tick_in,
  input wire logic                lock_loss_switch_inhibit_in,
  input wire logic [NUM_REFS-1:0] signal_loss_out,
  input wire logic                holdover_out,
  input wire logic                rail_high_out,
  input wire logic                rail_low_out,
  input wire logic                switch_event_out,
  input wire logic                status1_oe_out,
  input wire logic                status1_pullup_out,
  input wire logic                status1_pulldown_out
);
  default clocking mon_cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  a_switch_one_pulse: assert property (switch_event_out |=> !switch_event_out)
    else $error("switch event wider than one cycle");
  a_lockfall_enters_hold: assert property (
    $fell(first_loop_lock_flag_in) && !lock_loss_switch_inhibit_in |-> ##[0:2] holdover_out)
    else $error("lock fall did not enter holdover");
  a_inhibit_no_switch: assert property (
    $fell(first_loop_lock_flag_in) && lock_loss_switch_inhibit_in && !rail_high_out
    && !rail_low_out |-> !switch_event_out [*3]) else $error("inhibited lock fall switched");
  a_rail_enters_hold: assert property (
    $rose(rail_high_out) || $rose(rail_low_out) |-> $past(holdover_out) or ##[0:2] holdover_out)
    else $error("rail trip did not enter holdover");
  // Only a fresh trip counts, a second rail rising while one is set is not required to switch again
  a_rail_gives_switch: assert property (
    ($rose(rail_high_out) || $rose(rail_low_out)) && !$past(rail_high_out)
    && !$past(rail_low_out) |-> $past(switch_event_out) or ##[0:2] switch_event_out)
    else $error("rail trip gave no switch event");
  a_exit_needs_lock: assert property ($fell(holdover_out) |->
    $past(first_loop_lock_flag_in) && !rail_high_out && !rail_low_out)
    else $error("holdover left without lock or with trip");
  a_exit_after_tick: assert property (
    $fell(holdover_out) |-> $past(pd_tick_in) || $past(pd_tick_in, 2))
    else $error("holdover left without detector tick");
  a_pull_exclusive: assert property (!(status1_pullup_out && status1_pulldown_out))
    else $error("both pulls requested");
  a_drive_no_pull: assert property (
    status1_oe_out |-> !status1_pullup_out && !status1_pulldown_out)
    else $error("pull requested while driving");
  a_loss_clears: assert property ($changed(ref_clk_in[1]) |-> ##[1:2] !signal_loss_out[1])
    else $error("signal loss kept despite activity");
  a_loss_needs_quiet: assert property (
    $rose(signal_loss_out[1]) |-> $past(ref_clk_in[1]) == $past(ref_clk_in[1], 2))
    else $error("signal loss flagged during activity");

  c_lock_fall: cover property ($fell(first_loop_lock_flag_in) && !lock_loss_switch_inhibit_in);
  c_rail_high: cover property ($rose(rail_high_out));
  c_hold_exit: cover property ($fell(holdover_out));
endmodule

/* File: tb_rlh_holdover_ctrl.sv */
`timescale 1ns/10ps
module tb_rlh_holdover_ctrl;
  import rlh_pkg::*;
  typedef struct {int id; logic [31:0] v;} rlh_note_t;
  logic        clk_in = 0, arst_n_in = 0, uclk = 0, udata = 0, ule = 0;
  logic        lock = 1, tick = 0, trk_en = 0, inhib = 0;
  logic [2:0]  ref_clk = 0, ref_run = 3'h7, los, bsel;
  logic [9:0]  trk = 0, tune;
  logic        rb, hold, rhi, rlo, sw, so, soe, spu, spd;
  logic [31:0] rb_word = 0;
  int          fail_count = 0, tests_run = 0, sw_cnt = 0;
  rlh_note_t   q[$];
  rlh_note_t   n;
  string       nm[7] = '{"signal_loss", "tune_code", "hold_rails", "status_pin",
                         "buffer_select", "readback", "switch_events"};

  rlh_holdover_ctrl rlh_holdover_ctrl_i (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .ce_in(1'b1), .uwire_clk_in(uclk),
    .uwire_data_in(udata), .uwire_le_in(ule), .ref_clk_in(ref_clk),
    .first_loop_lock_flag_in(lock), .pd_tick_in(tick), .tune_track_code_in(trk),
    .track_enable_in(trk_en), .lock_loss_switch_inhibit_in(inhib), .readback_out(rb),
    .signal_loss_out(los), .tune_code_out(tune), .holdover_out(hold), .rail_high_out(rhi),
    .rail_low_out(rlo), .switch_event_out(sw), .status1_o_out(so), .status1_oe_out(soe),
    .status1_pullup_out(spu), .status1_pulldown_out(spd), .ref_input_buffer_select_out(bsel));

  initial forever #12.5 clk_in = ~clk_in;
  always @(posedge clk_in) ref_clk <= #1 ref_clk ^ ref_run;
  always @(posedge clk_in) if (sw === 1'b1) sw_cnt <= sw_cnt + 1;

  function automatic logic [31:0] obs(input int id);
    case (id)
      0: return 32'(los);
      1: return 32'(tune);
      2: return 32'({hold, rhi, rlo});
      3: return 32'({so, soe, spu, spd});
      4: return 32'(bsel);
      5: return rb_word;
      default: return 32'(sw_cnt);
    endcase
  endfunction

  function automatic logic [31:0] mon_w(input logic [1:0] sel, input logic en,
    input logic [2:0] pin, input logic [2:0] bs, input logic [5:0] hi, input logic [5:0] lo,
    input logic rail);
    return {sel, 1'b0, en, 1'b0, pin, 1'b0, bs, hi, 2'b00, lo, rail, RLH_ADDR_INPUT_MON};
  endfunction

  function automatic logic [31:0] hold_w(input logic [9:0] man, input logic mode,
    input logic frc);
    return {man, 1'b0, mode, 14'd3, frc, RLH_ADDR_DAC_HOLD};
  endfunction

  task cyc(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask

  task chk(input int id, input logic [31:0] v);
    q.push_back('{id, v});
  endtask

  // Serial phases kept at two cycles, above the one cycle each phase needs to be sampled
  task wr(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      udata = w[i];
      cyc(2);
      uclk = 1'b1;
      cyc(2);
      uclk = 1'b0;
    end
    cyc(2);
    ule = 1'b1;
    cyc(2);
    ule = 1'b0;
    cyc(3);
  endtask

  // Latch re-commits the last shifted word; same value, so harmless
  task rd();
    udata = 1'b0;
    ule = 1'b1;
    cyc(3);
    rb_word[31] = rb;
    ule = 1'b0;
    for (int i = 30; i >= 0; i--) begin
      uclk = 1'b1;
      cyc(3);
      rb_word[i] = rb;
      uclk = 1'b0;
      cyc(2);
    end
  endtask

  task ticks(input int k);
    repeat (k) begin
      tick = 1'b1;
      cyc(1);
      tick = 1'b0;
      cyc(2);
    end
  endtask

  task finish_test();
    if (fail_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial forever begin
    wait (q.size() > 0);
    n = q.pop_front();
    tests_run++;
    if (obs(n.id) !== n.v) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm[n.id], n.v, obs(n.id));
    end
  end

  initial begin
    #750000;
    fail_count++;
    finish_test();
  end

  initial begin
    logic [3:0] pin_exp[7] = '{4'h0, 4'h2, 4'h1, 4'h4, 4'hc, 4'h8, 4'h4};
    int         los_cyc[4] = '{48, 9, 3, 1};
    int         codes[6] = '{959, 960, 500, 64, 63, 500};
    int         rexp[6] = '{0, 6, 4, 4, 5, 4};
    int         swexp[6] = '{1, 2, 2, 2, 3, 3};
    logic [2:0] b;
    logic [9:0] r;
    void'($urandom(32'h237b));
    cyc(8);
    arst_n_in = 1'b1;
    cyc(1);
    for (int i = 0; i < 5; i++) chk(i, 0);
    rd();
    chk(5, 0);
    for (int s = 0; s < 7; s++) begin
      b = 3'($urandom);
      wr(mon_w(2'b00, 1'b0, 3'(s), b, 6'h0, 6'h0, 1'b0));
      chk(3, pin_exp[s]);
      chk(4, b);
    end
    for (int s = 0; s < 4; s++) begin
      wr(mon_w(2'(s), 1'b1, RLH_PIN_OD, 3'h0, 6'h0, 6'h0, 1'b0));
      ref_run = 3'h5;
      if (los_cyc[s] > 4) begin
        cyc(los_cyc[s] - 3);
        chk(0, 0);
      end
      cyc(6);
      chk(0, 3'h2);
      chk(3, 4'h0);
      ref_run = 3'h7;
      cyc(3);
      chk(0, 0);
    end
    ref_run = 3'h5;
    wr(mon_w(2'b11, 1'b0, RLH_PIN_IN, 3'h0, 6'h0, 6'h0, 1'b0));
    chk(0, 0);
    ref_run = 3'h7;
    trk_en = 1'b1;
    r = 10'($urandom_range(900));
    trk = r;
    cyc(3);
    chk(1, r);
    rd();
    chk(5, {8'h00, r, 14'h0000});
    wr(hold_w(10'h155, 1'b0, 1'b1));
    trk = ~r;
    cyc(2);
    chk(2, 3'b100);
    chk(1, r);
    chk(6, 0);
    trk_en = 1'b0;
    cyc(3);
    chk(1, 10'h155);
    wr(hold_w(10'h155, 1'b0, 1'b0));
    ticks(2);
    chk(2, 3'b100);
    ticks(1);
    chk(2, 0);
    lock = 1'b0;
    cyc(4);
    chk(2, 3'b100);
    chk(6, 1);
    lock = 1'b1;
    ticks(3);
    chk(2, 0);
    inhib = 1'b1;
    lock = 1'b0;
    cyc(4);
    chk(2, 0);
    chk(6, 1);
    lock = 1'b1;
    inhib = 1'b0;
    wr(mon_w(2'b00, 1'b0, RLH_PIN_IN, 3'h0, 6'd3, 6'd3, 1'b1));
    for (int i = 0; i < 6; i++) begin
      wr(hold_w(10'(codes[i]), 1'b1, 1'b0));
      chk(1, codes[i]);
      chk(2, rexp[i]);
      chk(6, swexp[i]);
    end
    ticks(3);
    chk(2, 0);
    wr(hold_w(10'h2aa, 1'b0, 1'b0));
    trk_en = 1'b1;
    trk = 10'h123;
    cyc(3);
    chk(1, 10'h123);
    cyc(2);
    finish_test();
  end
endmodule

bind rlh_holdover_ctrl rlh_holdover_ctrl_monitor #(.NUM_REFS(NUM_REFS)) rlh_holdover_ctrl_monitor_i (
  .clk_in(clk_in), .arst_n_in(arst_n_in), .ref_clk_in(ref_clk_in),
  .first_loop_lock_flag_in(first_loop_lock_flag_in), .pd_tick_in(pd_tick_in),
  .lock_loss_switch_inhibit_in(lock_loss_switch_inhibit_in), .signal_loss_out(signal_loss_out),
  .holdover_out(holdover_out), .rail_high_out(rail_high_out), .rail_low_out(rail_low_out),
  .switch_event_out(switch_event_out), .status1_oe_out(status1_oe_out),
  .status1_pullup_out(status1_pullup_out), .status1_pulldown_out(status1_pulldown_out));
